// ---- verif/plmc_board.sv ----
// Purpose: board logic on the far side of the two-way pins
// Assumes: board drives every pin that the fabric leaves undriven
// Notes: resolves the wire level fed back to the fabric
`timescale 1ns/1ps
module plmc_board (
   input wire plmc_pkg::pin_out_type i_pins,
   input wire logic [plmc_pkg::NUM_IO-1:0] i_board,
   output logic [plmc_pkg::NUM_IO-1:0] o_io
);
   // board lets go of a pin while the fabric drives it
   always_comb begin
      for (int k = 0; k < plmc_pkg::NUM_IO; k++) begin
         o_io[k] = i_pins.oe[k] ? i_pins.drv[k] : i_board[k];
      end
   end
endmodule : plmc_board

// ---- verif/product_term_macrocell_block_tb.sv ----
// Purpose: self-checking bench for the macrocell fabric
// Assumes: inputs change at the falling clock edge
// Notes: pins 24..26 of block 3 serve as data, reset and preset inputs
`timescale 1ns/1ps
module product_term_macrocell_block_tb;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [plmc_pkg::NUM_DED-1:0] ded = '0;
   logic [plmc_pkg::NUM_CKP-1:0] ckp = '0;
   logic [plmc_pkg::NUM_IO-1:0] board = '0;
   logic [plmc_pkg::NUM_IO-1:0] io;
   plmc_pkg::fab_cfg_type cfg = '0;
   plmc_pkg::pin_out_type pins;
   int err_count = 0;
   int total_checks = 0;

   always #50 core_clk = ~core_clk;

   plmc_fabric dut_u (.i_core_clk(core_clk), .i_rstn(rst_n), .i_ded(ded), .i_clk_pin(ckp),
      .i_io(io), .i_cfg(cfg), .o_pins(pins));
   plmc_board board_u (.i_pins(pins), .i_board(board), .o_io(io));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string name, input logic seen, input logic exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0b seen %0b", name, exp, seen);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(negedge core_clk);
   endtask : settle

   task automatic pin(input int k, input logic v);
      board[k] = v;
      settle(3);
   endtask : pin

   task automatic pulse(input int k);
      ckp[k] = 1'b1;
      settle(3);
      ckp[k] = 1'b0;
      settle(3);
   endtask : pulse

   task automatic oe_case(input logic [1:0] m, input logic s, input logic e);
      cfg[0].ioc[0].oe_mode = plmc_pkg::oe_mode_type'(m);
      cfg[0].ioc[0].oe_sel = s;
      settle(3);
      check("oe0", pins.oe[0], e);
   endtask : oe_case

   initial begin
      for (int c = 0; c < 20000; c++) begin
         @(posedge core_clk);
      end
      err_count++;
      $display("[FAIL] watchdog expected done seen hang");
      complete_run();
   end

   initial begin
      settle(4);
      rst_n = 1'b1;
      // block 0 reads pins 24, 25, 26
      cfg[0].route[0] = 7'h5E;
      cfg[0].route[1] = 7'h5F;
      cfg[0].route[2] = 7'h60;
      cfg[0].terms[8] = 44'h1;
      cfg[0].terms[16] = 44'h1;
      cfg[0].terms[65] = 44'h1;
      cfg[0].terms[66] = 44'h2;
      cfg[0].terms[67] = 44'h4;
      cfg[0].clus[2].en = 1'h1;
      cfg[0].clus[4].en = 1'h1;
      cfg[0].ioc[0].oe_mode = plmc_pkg::OE_ON;
      cfg[0].ioc[1].oe_mode = plmc_pkg::OE_ON;
      // block 1 reads macrocell 0 of block 0
      cfg[1].route[0] = 7'h06;
      cfg[1].terms[8] = 44'h1;
      cfg[1].clus[2].en = 1'h1;
      cfg[1].ioc[0].oe_mode = plmc_pkg::OE_ON;
      pin(24, 1'b1);
      settle(1);
      check("drv0", pins.drv[0], 1'b1);
      check("drv8", pins.drv[8], 1'b1);
      pin(24, 1'b0);
      settle(1);
      check("drv0", pins.drv[0], 1'b0);
      check("drv8", pins.drv[8], 1'b0);
      cfg[0].mc[0].invert = 1'h1;
      settle(4);
      check("drv0", pins.drv[0], 1'b1);
      cfg[0].mc[0].invert = 1'h0;
      $display("test comb done");
      pin(24, 1'b1);
      oe_case(2'h0, 1'h0, 1'b0);
      oe_case(2'h1, 1'h0, 1'b1);
      oe_case(2'h2, 1'h0, 1'b0);
      oe_case(2'h3, 1'h1, 1'b1);
      oe_case(2'h3, 1'h0, 1'b0);
      pin(24, 1'b0);
      oe_case(2'h3, 1'h1, 1'b0);
      cfg[0].ioc[0].oe_mode = plmc_pkg::OE_ON;
      $display("test enable done");
      cfg[0].mc[0].mode = plmc_pkg::MC_REG;
      cfg[0].mc[0].clk_sel = 1'h1;
      cfg[0].mc[2].mode = plmc_pkg::MC_REG;
      cfg[0].mc[2].clk_sel = 1'h1;
      pin(25, 1'b1);
      pin(25, 1'b0);
      check("drv0", pins.drv[0], 1'b0);
      pin(24, 1'b1);
      check("drv0", pins.drv[0], 1'b0);
      pulse(0);
      check("drv0", pins.drv[0], 1'b0);
      pulse(1);
      check("drv0", pins.drv[0], 1'b1);
      check("drv1", pins.drv[1], 1'b1);
      pin(24, 1'b0);
      pulse(1);
      check("drv0", pins.drv[0], 1'b0);
      cfg[0].mc[0].t_type = 1'h1;
      pin(24, 1'b1);
      pulse(1);
      check("drv0", pins.drv[0], 1'b1);
      pulse(1);
      check("drv0", pins.drv[0], 1'b0);
      $display("test register done");
      pin(24, 1'b0);
      pin(26, 1'b1);
      check("drv0", pins.drv[0], 1'b1);
      check("drv1", pins.drv[1], 1'b1);
      pin(26, 1'b0);
      check("drv0", pins.drv[0], 1'b1);
      pin(25, 1'b1);
      check("drv0", pins.drv[0], 1'b0);
      pin(26, 1'b1);
      check("drv0", pins.drv[0], 1'b0);
      check("drv1", pins.drv[1], 1'b0);
      pin(26, 1'b0);
      pin(25, 1'b0);
      $display("test init done");
      cfg[0].mc[0].mode = plmc_pkg::MC_LATCH;
      cfg[0].mc[0].t_type = 1'h0;
      cfg[0].mc[0].clk_sel = 1'h0;
      pin(24, 1'b1);
      check("drv0", pins.drv[0], 1'b1);
      ckp[0] = 1'b1;
      pin(24, 1'b0);
      check("drv0", pins.drv[0], 1'b1);
      ckp[0] = 1'b0;
      settle(3);
      check("drv0", pins.drv[0], 1'b0);
      $display("test latch done");
      cfg[0].ioc[0].oe_mode = plmc_pkg::OE_OFF;
      cfg[0].mc[1].mode = plmc_pkg::MC_IN_REG;
      cfg[1].route[1] = 7'h07;
      cfg[1].terms[16] = 44'h2;
      cfg[1].clus[4].en = 1'h1;
      cfg[1].ioc[1].oe_mode = plmc_pkg::OE_ON;
      pin(0, 1'b1);
      settle(1);
      check("drv9", pins.drv[9], 1'b0);
      pulse(0);
      check("drv9", pins.drv[9], 1'b1);
      $display("test input register done");
      cfg[0].mc[1].mode = plmc_pkg::MC_IN_LATCH;
      pin(0, 1'b0);
      check("drv9", pins.drv[9], 1'b0);
      ckp[0] = 1'b1;
      pin(0, 1'b1);
      check("drv9", pins.drv[9], 1'b0);
      ckp[0] = 1'b0;
      settle(3);
      check("drv9", pins.drv[9], 1'b1);
      $display("test input latch done");
      cfg[2].route[0] = 7'h03;
      cfg[2].route[1] = 7'h05;
      cfg[2].terms[8] = 44'h1;
      cfg[2].terms[16] = 44'h2;
      cfg[2].clus[2].en = 1'h1;
      cfg[2].clus[4].en = 1'h1;
      cfg[2].ioc[0].oe_mode = plmc_pkg::OE_ON;
      cfg[2].ioc[1].oe_mode = plmc_pkg::OE_ON;
      settle(3);
      check("drv16", pins.drv[16], 1'b0);
      ded[3] = 1'b1;
      settle(3);
      check("drv16", pins.drv[16], 1'b1);
      ckp[1] = 1'b1;
      settle(3);
      check("drv17", pins.drv[17], 1'b1);
      ckp[1] = 1'b0;
      settle(3);
      check("drv17", pins.drv[17], 1'b0);
      $display("test dedicated input done");
      complete_run();
   end
endmodule : product_term_macrocell_block_tb

// ---- verilog/plmc_fabric.sv ----
// Purpose: four product-term blocks joined by a routing matrix
// Assumes: pins and configuration are synchronous to i_core_clk
// Notes: routing pool is registered, so feedback paths hold no loops
`timescale 1ns/1ps
module plmc_fabric (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic [plmc_pkg::NUM_DED-1:0] i_ded,
   input wire logic [plmc_pkg::NUM_CKP-1:0] i_clk_pin,
   input wire logic [plmc_pkg::NUM_IO-1:0] i_io,
   input wire plmc_pkg::fab_cfg_type i_cfg,
   output plmc_pkg::pin_out_type o_pins
);
   logic [plmc_pkg::POOL_W-1:0] pool_q;
   logic [plmc_pkg::POOL_W-1:0] pool_d;
   logic [plmc_pkg::NUM_CKP-1:0] ck_prev_q;
   logic [plmc_pkg::NUM_CKP-1:0] ck_rise;
   wire [plmc_pkg::NUM_BLK*plmc_pkg::NUM_MC-1:0] mc_val;
   wire [plmc_pkg::NUM_IO-1:0] drv_w;
   wire [plmc_pkg::NUM_IO-1:0] oe_w;

   // clock pins: edge detect for registers, level for latches
   assign ck_rise = i_clk_pin & ~ck_prev_q;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ck_prev_q <= '0;
      end else begin
         ck_prev_q <= i_clk_pin;
      end
   end

   // routing pool: inputs, clock pins, macrocell and pin feedback
   assign pool_d = {i_io, mc_val, i_clk_pin, i_ded};

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pool_q <= '0;
      end else begin
         pool_q <= pool_d;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pins <= '0;
      end else begin
         o_pins.drv <= drv_w;
         o_pins.oe <= oe_w;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   chk_clk_as_data: assert property (##1 pool_q[plmc_pkg::POOL_CKP +: plmc_pkg::NUM_CKP]
                                     == $past(i_clk_pin))
      else $error("clock pin not usable as data");
   chk_pin_fb: assert property (##1 pool_q[plmc_pkg::POOL_IO +: plmc_pkg::NUM_IO]
                                == $past(i_io))
      else $error("pin feedback missing from matrix");

   genvar b;
   genvar i;
   genvar t;
   genvar c;
   genvar m;
   genvar k;
   generate
      for (b = 0; b < plmc_pkg::NUM_BLK; b++) begin : g_blk
         logic [plmc_pkg::BLK_IN-1:0] blk_in;
         logic [plmc_pkg::LIT_W-1:0] lit;
         logic [plmc_pkg::NUM_PT+plmc_pkg::NUM_SPT-1:0] term;
         logic [plmc_pkg::NUM_CL-1:0] cl_or;
         logic [plmc_pkg::NUM_MC-1:0] mc_sum;
         logic rst_term;
         logic pre_term;

         // matrix: each block selects its inputs from the pool
         for (i = 0; i < plmc_pkg::BLK_IN; i++) begin : g_route
            assign blk_in[i] = (i_cfg[b].route[i] < plmc_pkg::SEL_W'(plmc_pkg::POOL_W)) ?
                               pool_q[i_cfg[b].route[i]] : 1'b0;
         end
         assign lit = {~blk_in, blk_in};

         // product terms: an empty mask leaves the term false
         for (t = 0; t < plmc_pkg::NUM_PT + plmc_pkg::NUM_SPT; t++) begin : g_term
            assign term[t] = (|i_cfg[b].terms[t]) &&
                             ((lit & i_cfg[b].terms[t]) == i_cfg[b].terms[t]);
         end

         for (c = 0; c < plmc_pkg::NUM_CL; c++) begin : g_clus
            assign cl_or[c] = |term[c*plmc_pkg::CL_TERMS +: plmc_pkg::CL_TERMS];
         end

         // allocator: each cluster steered to one macrocell of its window
         for (m = 0; m < plmc_pkg::NUM_MC; m++) begin : g_alloc
            always_comb begin
               mc_sum[m] = 1'b0;
               for (int cc = 0; cc < plmc_pkg::NUM_CL; cc++) begin
                  if (i_cfg[b].clus[cc].en &&
                      (cc - plmc_pkg::WIN_LO + int'(i_cfg[b].clus[cc].off)) == m) begin
                     mc_sum[m] = mc_sum[m] | cl_or[cc];
                  end
               end
            end

            chk_sum_window: assert property (mc_sum[m] |->
               |(cl_or[(m < 1 ? 0 : m - 1) : (m + 2 > 15 ? 15 : m + 2)]))
               else $error("macrocell fed from outside its window");
         end

         // one reset and one preset term for every macrocell of the block
         assign rst_term = term[plmc_pkg::NUM_PT + plmc_pkg::SPT_RST];
         assign pre_term = term[plmc_pkg::NUM_PT + plmc_pkg::SPT_PRE];

         for (m = 0; m < plmc_pkg::NUM_MC; m++) begin : g_mc
            plmc_macrocell #(
               .IS_BURIED(m % 2 == 1)
            ) u_mc (
               .i_core_clk(i_core_clk),
               .i_rstn(i_rstn),
               .i_sum(mc_sum[m]),
               .i_pin(i_io[b*plmc_pkg::NUM_IOC + m/2]),
               .i_ck_rise(ck_rise),
               .i_gate(i_clk_pin),
               .i_rst_term(rst_term),
               .i_pre_term(pre_term),
               .i_cfg(i_cfg[b].mc[m]),
               .o_val(mc_val[b*plmc_pkg::NUM_MC + m])
            );
         end

         // i/o cells: even macrocells drive the pins
         for (k = 0; k < plmc_pkg::NUM_IOC; k++) begin : g_ioc
            localparam int PIN = b * plmc_pkg::NUM_IOC + k;
            assign drv_w[PIN] = mc_val[b*plmc_pkg::NUM_MC + 2*k];
            assign oe_w[PIN] =
               (i_cfg[b].ioc[k].oe_mode == plmc_pkg::OE_ON) ? 1'b1 :
               (i_cfg[b].ioc[k].oe_mode == plmc_pkg::OE_TERM) ?
                  term[plmc_pkg::NUM_PT + plmc_pkg::SPT_OE0 + int'(i_cfg[b].ioc[k].oe_sel)] :
                  1'b0;

            chk_oe_off: assert property (i_cfg[b].ioc[k].oe_mode == plmc_pkg::OE_OFF
                                         |=> !o_pins.oe[PIN])
               else $error("disabled driver was enabled");
            chk_oe_on: assert property (i_cfg[b].ioc[k].oe_mode == plmc_pkg::OE_ON
                                        |=> o_pins.oe[PIN])
               else $error("always-on driver was disabled");
            chk_oe_term: assert property (i_cfg[b].ioc[k].oe_mode == plmc_pkg::OE_TERM
               |=> o_pins.oe[PIN] == $past(term[plmc_pkg::NUM_PT + plmc_pkg::SPT_OE0
                                            + int'(i_cfg[b].ioc[k].oe_sel)]))
               else $error("driver enable not from chosen term");
            chk_pin_drive: assert property (##1 o_pins.drv[PIN]
               == $past(mc_val[b*plmc_pkg::NUM_MC + 2*k]))
               else $error("pin not driven by its output macrocell");
         end

         chk_fb_pool: assert property (##1 pool_q[plmc_pkg::POOL_MC + b*plmc_pkg::NUM_MC +:
            plmc_pkg::NUM_MC] == $past(mc_val[b*plmc_pkg::NUM_MC +: plmc_pkg::NUM_MC]))
            else $error("macrocell feedback lost");
      end
   endgenerate
endmodule : plmc_fabric

// ---- verilog/plmc_macrocell.sv ----
// Purpose: one macrocell: combinational, register or latch storage
// Assumes: clock rise and gate levels come from sampled clock pins
// Notes: reset and preset terms force the stored value at once
`timescale 1ns/1ps
module plmc_macrocell #(
   parameter bit IS_BURIED = 1'b0
) (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_sum,
   input wire logic i_pin,
   input wire logic [plmc_pkg::NUM_CKP-1:0] i_ck_rise,
   input wire logic [plmc_pkg::NUM_CKP-1:0] i_gate,
   input wire logic i_rst_term,
   input wire logic i_pre_term,
   input wire plmc_pkg::mc_cfg_type i_cfg,
   output logic o_val
);
   logic q_q;
   logic q_d;
   logic d_in;
   logic rise;
   logic gate;
   logic is_reg;
   logic is_lat;
   logic nxt;
   logic held;

   assign is_reg = (i_cfg.mode == plmc_pkg::MC_REG) ||
                   (IS_BURIED && i_cfg.mode == plmc_pkg::MC_IN_REG);
   assign is_lat = (i_cfg.mode == plmc_pkg::MC_LATCH) ||
                   (IS_BURIED && i_cfg.mode == plmc_pkg::MC_IN_LATCH);
   assign d_in = (IS_BURIED && (i_cfg.mode == plmc_pkg::MC_IN_REG ||
                  i_cfg.mode == plmc_pkg::MC_IN_LATCH)) ? i_pin : i_sum;
   assign rise = i_ck_rise[i_cfg.clk_sel];
   assign gate = i_gate[i_cfg.clk_sel];

   always_comb begin
      nxt = q_q;
      if (is_reg && rise) begin
         nxt = i_cfg.t_type ? (q_q ^ d_in) : d_in;
      end else if (is_lat && !gate) begin
         nxt = d_in;
      end
      if (i_rst_term) begin
         q_d = plmc_pkg::FORCE_LO;
      end else if (i_pre_term) begin
         q_d = plmc_pkg::FORCE_HI;
      end else begin
         q_d = nxt;
      end
   end

   always_comb begin
      if (is_reg) begin
         held = i_rst_term ? plmc_pkg::FORCE_LO : (i_pre_term ? plmc_pkg::FORCE_HI : q_q);
      end else if (is_lat) begin
         held = q_d;
      end else begin
         held = i_sum;
      end
      o_val = held ^ i_cfg.invert;
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q_q <= plmc_pkg::FORCE_LO;
      end else begin
         q_q <= q_d;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_clean_edge;
      is_reg && rise && !i_rst_term && !i_pre_term;
   endsequence

   chk_rst_wins: assert property ((is_reg || is_lat) && i_rst_term |-> o_val == i_cfg.invert)
      else $error("reset term did not force zero");
   chk_pre_sets: assert property ((is_reg || is_lat) && !i_rst_term && i_pre_term
                                  |-> o_val == !i_cfg.invert)
      else $error("preset term did not force one");
   chk_d_capture: assert property (s_clean_edge and !i_cfg.t_type |=> q_q == $past(d_in))
      else $error("d register missed its data");
   chk_t_toggle: assert property (s_clean_edge and i_cfg.t_type
                                  |=> q_q == ($past(q_q) ^ $past(d_in)))
      else $error("toggle register wrong");
   chk_reg_hold: assert property (is_reg && !rise && !i_rst_term && !i_pre_term
                                  |=> q_q == $past(q_q))
      else $error("register changed without rising edge");
   chk_latch_gate: assert property (is_lat && !i_rst_term && !i_pre_term
                                    |-> o_val == ((gate ? q_q : d_in) ^ i_cfg.invert))
      else $error("latch gate behaviour wrong");
endmodule : plmc_macrocell

// ---- verilog/plmc_pkg.sv ----
// Purpose: shared constants and types for the product-term macrocell fabric
// Assumes: one core clock; all pins sampled synchronously
// Notes: configuration arrives as plain ports, no register bus
// Operation
// - 32 two-way and 4 input pins feed matrix
// - two clock/gate pins also usable as data
// - block: 64 terms, allocator, 8+8 macrocells, 8 cells
// - matrix gives each block exactly 22 inputs
// - four special terms: two enables, reset, preset
// - one reset/preset pair initialises whole block
// - block returns 16 macrocell, 8 pin feedbacks
// - allocator gives one macrocell at most 16 terms
// - macrocell sees only its sliding cluster window
// - registered, latched or combinational, with polarity
// - macrocell result always fed back internally
// - register works as D or toggle type
// - each storage element picks its clock pin
// - register captures on rising clock edge
// - latch passes when gate low, holds high
// - reset term clears, preset term sets, unclocked
// - buried macrocell adds input register or latch
// - driver always on, always off, or term
// - term control picks one of two enables
package plmc_pkg;
   localparam int NUM_BLK = 4;
   localparam int NUM_IO = 32;
   localparam int NUM_DED = 4;
   localparam int NUM_CKP = 2;
   localparam int BLK_IN = 22;
   localparam int NUM_PT = 64;
   localparam int NUM_SPT = 4;
   localparam int NUM_MC = 16;
   localparam int NUM_IOC = 8;
   localparam int NUM_CL = 16;
   localparam int CL_TERMS = 4;
   localparam int MAX_MC_PT = 16;
   localparam int LIT_W = 2 * BLK_IN;
   localparam int SEL_W = 7;
   localparam int POOL_DED = 0;
   localparam int POOL_CKP = POOL_DED + NUM_DED;
   localparam int POOL_MC = POOL_CKP + NUM_CKP;
   localparam int POOL_IO = POOL_MC + NUM_BLK * NUM_MC;
   localparam int POOL_W = POOL_IO + NUM_IO;
   localparam int SPT_OE0 = 0;
   localparam int SPT_RST = 2;
   localparam int SPT_PRE = 3;
   localparam int WIN_LO = 2;
   localparam logic FORCE_LO = 1'h0;
   localparam logic FORCE_HI = 1'h1;

   typedef enum logic [2:0] {
      MC_COMB = 3'h0,
      MC_REG = 3'h1,
      MC_LATCH = 3'h3,
      MC_IN_REG = 3'h2,
      MC_IN_LATCH = 3'h6
   } mc_mode_type;

   typedef enum logic [1:0] {
      OE_OFF = 2'h0,
      OE_ON = 2'h1,
      OE_TERM = 2'h3
   } oe_mode_type;

   typedef struct packed {
      mc_mode_type mode;
      logic t_type;
      logic invert;
      logic clk_sel;
   } mc_cfg_type;

   typedef struct packed {
      oe_mode_type oe_mode;
      logic oe_sel;
   } io_cfg_type;

   typedef struct packed {
      logic en;
      logic [1:0] off;
   } cl_cfg_type;

   typedef struct packed {
      logic [BLK_IN-1:0][SEL_W-1:0] route;
      logic [NUM_PT+NUM_SPT-1:0][LIT_W-1:0] terms;
      cl_cfg_type [NUM_CL-1:0] clus;
      mc_cfg_type [NUM_MC-1:0] mc;
      io_cfg_type [NUM_IOC-1:0] ioc;
   } blk_cfg_type;

   typedef blk_cfg_type [NUM_BLK-1:0] fab_cfg_type;

   typedef struct packed {
      logic [NUM_IO-1:0] drv;
      logic [NUM_IO-1:0] oe;
   } pin_out_type;
endpackage : plmc_pkg
